// ---- logic/rimb_consts.svh ----
// Offsets, field layouts, reset values and counts of the receive mask bank
`ifndef RIMB_CONSTS_SVH
`define RIMB_CONSTS_SVH

// Register indices; byte address on APB is four times the index
`define RIMB_IDX_GRP3        10'h0A2
`define RIMB_IDX_GRP4        10'h0A3
`define RIMB_IDX_HDLC        10'h0A4
`define RIMB_IDX_GRP7        10'h0A6
`define RIMB_IDX_CSE1        10'h0A8
`define RIMB_IDX_CSE2        10'h0A9
`define RIMB_IDX_CSE3        10'h0AA
`define RIMB_IDX_CSE4        10'h0AB
`define RIMB_IDX_LUP1        10'h0AC
`define RIMB_IDX_CFG         10'h0C0
`define RIMB_IDX_STAT        10'h0C1

// Implemented bits of each mask register
`define RIMB_IMPL_GRP3_T1    8'hFF
`define RIMB_IMPL_GRP3_E1    8'hBB
`define RIMB_IMPL_GRP4       8'hEF
`define RIMB_IMPL_HDLC       8'h3F
`define RIMB_IMPL_GRP7_T1    8'h3F
`define RIMB_IMPL_GRP7_E1    8'h03
`define RIMB_IMPL_CFG        8'h0F

// Reset value shared by every register of the bank
`define RIMB_RESET_VAL       8'h00

// Configuration register fields
`define RIMB_CFG_E1_BIT      0
`define RIMB_CFG_LEN_LSB     1
`define RIMB_CFG_LEN_MSB     3

// Own status register fields
`define RIMB_STAT_LUP_BIT    0
`define RIMB_STAT_IRQ_BIT    1

// Summary bit positions of each status group
`define RIMB_SUM_GRP3        2
`define RIMB_SUM_GRP4        3
`define RIMB_SUM_HDLC        4
`define RIMB_SUM_GRP7        6

// Signaling change flag position in latched status group 4
`define RIMB_SIG_CHANGE_BIT  3

// Default loop-up integration length in received bits
`define RIMB_INTEG_BITS      48

`endif

// ---- logic/rimb_pkg.sv ----
// Types shared by the receive interrupt mask bank
`default_nettype none

package rimb_pkg;

  typedef enum logic {
    RIMB_T1,
    RIMB_E1
  } rimb_mode_t;

  typedef logic [7:0] rimb_byte_t;

endpackage

`default_nettype wire

// ---- logic/rimb_bank.sv ----
// Receive interrupt mask bank with APB register access and loop-up detector
//
// Function
// - Each implemented mask bit passes its status source at one, blocks it at zero, and resets to zero.
// - In E1 mode group 3 enables clock-loss clear 7, link clear 5, distant alarm clear 4, clock-loss detect 3, link detect 1, distant alarm detect 0.
// - Group 4 enables elastic full 7, empty 6, slip 5, signaling change 3, one-second 2, timer 1, multiframe 0.
// - Group 5 enables HDLC overrun 5, opening byte 4, packet end 3, packet start 2, high watermark 1, not empty 0.
// - In T1 mode group 7 enables remote alarm CI 5, alarm signal CI 4, subscriber carrier 3, data-link full 2, code clear 1, code detect 0.
// - In E1 mode group 7 bit 1 enables the national bit 6 codeword interrupt.
// - In E1 mode group 7 bit 0 enables the national bit change interrupt, positions picked by a separate mask.
// - An enabled channel whose signaling changes sets the change flag, bit 3 of latched status group 4.
// - Four change enable registers cover channels 1-8, 9-16, 17-24, 25-32, lowest in bit 0, the last only in E1.
// - Any host write of the first loop-up pattern register restarts detector integration.
// - Pattern bit 7 is sent first, and positions beyond the selected length are ignored.
// - Group 3 has one address, with the E1 layout only in E1 mode and the T1 layout otherwise.
// - Group 7 has one address whose meaning follows the mode, with only bits 1 and 0 in E1.
// - Masked status bits are hidden from the summary, whose bit clears once its group has nothing unmasked pending.
// - The live loop-up status is high once the defined loop-up code has been received for INTEG_BITS bits in a row.
//
// Design decision made here: register access over APB.
`default_nettype none
`include "rimb_consts.svh"

module rimb_bank
  import rimb_pkg::*;
#(
  parameter int CHANNELS   = 32,
  parameter int INTEG_BITS = `RIMB_INTEG_BITS
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [7:0]       rx_latched_status_group3,
  input  wire logic [7:0]       rx_latched_status_group4,
  input  wire logic [7:0]       rx_latched_status_hdlc,
  input  wire logic [7:0]       rx_latched_status_group7,
  input  wire logic [CHANNELS-1:0] channel_signaling_changed,
  input  wire logic             rx_line_bit,
  input  wire logic             rx_line_bit_valid,
  output logic [7:0]            rx_irq_summary,
  output logic                  rx_irq,
  output logic                  signaling_change_flag,
  output logic                  loop_up_restart,
  output logic                  loop_up_detect,
  output logic                  line_mode_e1
);

  localparam int CNT_W = $clog2(INTEG_BITS + 1);

  if (CHANNELS != 32) begin : g_chan_check
    $error("rimb_bank serves exactly 32 channels");
  end
  if (INTEG_BITS < 1) begin : g_integ_check
    $error("rimb_bank needs an integration length of one bit or more");
  end

  // True when the last len bits are some rotation of the pattern
  function automatic logic code_match(input rimb_byte_t hist,
                                      input rimb_byte_t pat,
                                      input logic [3:0] len);
    logic any_rot;
    logic this_rot;
    int   pos;
    any_rot = 1'b0;
    for (int r = 0; r < 8; r++) begin
      this_rot = (r < int'(len));
      for (int j = 0; j < 8; j++) begin
        if (r < int'(len) && j < int'(len)) begin
          pos = (j + r) % int'(len);
          if (hist[int'(len) - 1 - j] != pat[7 - pos]) begin
            this_rot = 1'b0;
          end
        end
      end
      any_rot = any_rot | this_rot;
    end
    return any_rot;
  endfunction

  rimb_byte_t  grp3_mask;
  rimb_byte_t  grp4_mask;
  rimb_byte_t  hdlc_mask;
  rimb_byte_t  grp7_t1_mask;
  rimb_byte_t  grp7_e1_mask;
  rimb_byte_t  loop_up_pattern;
  rimb_byte_t  cfg;
  logic [31:0] channel_change_enables;
  rimb_mode_t  mode;

  logic [9:0]  idx;
  logic        access;
  logic        wr_en;
  logic        lane0;
  rimb_byte_t  wbyte;
  logic        mapped;
  rimb_byte_t  next_rdata;
  rimb_byte_t  grp3_impl;
  rimb_byte_t  grp7_eff;
  rimb_byte_t  grp7_impl;
  logic [31:0] chan_enable_eff;
  logic [3:0]  code_len;

  rimb_byte_t  line_hist;
  logic [CNT_W-1:0] integ_cnt;
  logic        line_match;
  logic        restart_now;
  logic        wr_lane;
  logic        misaligned;
  // Unmasked pending condition of each status group
  logic        grp3_pend;
  logic        grp4_pend;
  logic        hdlc_pend;
  logic        grp7_pend;

  assign idx    = paddr[11:2];
  assign access = psel & penable & ~pready;
  // Write lands on the edge where the master sees pready high
  assign wr_en  = psel & penable & pready & pwrite & mapped & ~pslverr;
  assign lane0  = pstrb[0];
  assign wbyte  = pwdata[7:0];
  // A clear lane 0 drops the data but not the detector restart
  assign wr_lane    = wr_en & lane0;
  assign misaligned = (paddr[1:0] != 2'b00);
  assign mode   = cfg[`RIMB_CFG_E1_BIT] ? RIMB_E1 : RIMB_T1;
  assign code_len = {1'b0, cfg[`RIMB_CFG_LEN_MSB:`RIMB_CFG_LEN_LSB]} + 4'h1;

  always_comb begin
    if (mode == RIMB_E1) begin
      grp3_impl = `RIMB_IMPL_GRP3_E1;
      grp7_impl = `RIMB_IMPL_GRP7_E1;
      grp7_eff  = grp7_e1_mask & `RIMB_IMPL_GRP7_E1;
    end else begin
      grp3_impl = `RIMB_IMPL_GRP3_T1;
      grp7_impl = `RIMB_IMPL_GRP7_T1;
      grp7_eff  = grp7_t1_mask & `RIMB_IMPL_GRP7_T1;
    end
  end

  // Channels 25 to 32 exist only on an E1 line
  assign chan_enable_eff = (mode == RIMB_E1) ? channel_change_enables
                         : {8'h00, channel_change_enables[23:0]};

  always_comb begin
    mapped = 1'b1;
    next_rdata = `RIMB_RESET_VAL;
    case (idx)
      `RIMB_IDX_GRP3: next_rdata = grp3_mask & grp3_impl;
      `RIMB_IDX_GRP4: next_rdata = grp4_mask;
      `RIMB_IDX_HDLC: next_rdata = hdlc_mask;
      `RIMB_IDX_GRP7: next_rdata = grp7_eff;
      `RIMB_IDX_CSE1: next_rdata = channel_change_enables[7:0];
      `RIMB_IDX_CSE2: next_rdata = channel_change_enables[15:8];
      `RIMB_IDX_CSE3: next_rdata = channel_change_enables[23:16];
      `RIMB_IDX_CSE4: next_rdata = channel_change_enables[31:24];
      `RIMB_IDX_LUP1: next_rdata = loop_up_pattern;
      `RIMB_IDX_CFG:  next_rdata = cfg;
      `RIMB_IDX_STAT: begin
        next_rdata[`RIMB_STAT_LUP_BIT] = loop_up_detect;
        next_rdata[`RIMB_STAT_IRQ_BIT] = rx_irq;
      end
      default: mapped = 1'b0;
    endcase
  end

  // One wait state keeps pready and prdata straight off flip-flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  // Unknown or misaligned addresses answer with an error and store nothing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else if (access) begin
      pslverr <= ~mapped | misaligned;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Read data holds until the next access; writes return zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (access) begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
    end
  end

  // One storage serves both layouts; the mode trims it on read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      grp3_mask <= `RIMB_RESET_VAL;
    end else if (wr_lane && idx == `RIMB_IDX_GRP3) begin
      grp3_mask <= wbyte & grp3_impl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      grp4_mask <= `RIMB_RESET_VAL;
    end else if (wr_lane && idx == `RIMB_IDX_GRP4) begin
      grp4_mask <= wbyte & `RIMB_IMPL_GRP4;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hdlc_mask <= `RIMB_RESET_VAL;
    end else if (wr_lane && idx == `RIMB_IDX_HDLC) begin
      hdlc_mask <= wbyte & `RIMB_IMPL_HDLC;
    end
  end

  // The two layouts keep separate storage at the one address
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      grp7_t1_mask <= `RIMB_RESET_VAL;
      grp7_e1_mask <= `RIMB_RESET_VAL;
    end else if (wr_lane && idx == `RIMB_IDX_GRP7) begin
      if (mode == RIMB_E1) begin
        grp7_e1_mask <= wbyte & grp7_impl;
      end else begin
        grp7_t1_mask <= wbyte & grp7_impl;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channel_change_enables <= 32'h0000_0000;
    end else if (wr_en && lane0) begin
      case (idx)
        `RIMB_IDX_CSE1: channel_change_enables[7:0]   <= wbyte;
        `RIMB_IDX_CSE2: channel_change_enables[15:8]  <= wbyte;
        `RIMB_IDX_CSE3: channel_change_enables[23:16] <= wbyte;
        `RIMB_IDX_CSE4: channel_change_enables[31:24] <= wbyte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loop_up_pattern <= `RIMB_RESET_VAL;
    end else if (wr_lane && idx == `RIMB_IDX_LUP1) begin
      loop_up_pattern <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg <= `RIMB_RESET_VAL;
    end else if (wr_lane && idx == `RIMB_IDX_CFG) begin
      cfg <= wbyte & `RIMB_IMPL_CFG;
    end
  end

  // Any write restarts, even with the same value or no lane enabled
  assign restart_now = wr_en & (idx == `RIMB_IDX_LUP1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loop_up_restart <= 1'b0;
    end else begin
      loop_up_restart <= restart_now;
    end
  end

  // Registered copy so the mode output leaves a flip-flop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_mode_e1 <= 1'b0;
    end else begin
      line_mode_e1 <= (mode == RIMB_E1);
    end
  end

  assign line_match = code_match({line_hist[6:0], rx_line_bit},
                                 loop_up_pattern, code_len);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_hist <= `RIMB_RESET_VAL;
    end else if (rx_line_bit_valid) begin
      line_hist <= {line_hist[6:0], rx_line_bit};
    end
  end

  // A single mismatched bit drops detection; no error tolerance
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      integ_cnt <= '0;
    end else if (restart_now) begin
      integ_cnt <= '0;
    end else if (rx_line_bit_valid) begin
      if (!line_match) begin
        integ_cnt <= '0;
      end else if (integ_cnt != CNT_W'(INTEG_BITS)) begin
        integ_cnt <= integ_cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loop_up_detect <= 1'b0;
    end else if (restart_now) begin
      loop_up_detect <= 1'b0;
    end else begin
      loop_up_detect <= (integ_cnt == CNT_W'(INTEG_BITS));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      signaling_change_flag <= 1'b0;
    end else begin
      signaling_change_flag <=
        |(channel_signaling_changed & chan_enable_eff);
    end
  end

  // True when any status bit is set with its enable at one
  function automatic logic any_unmasked(input rimb_byte_t status,
                                        input rimb_byte_t enable);
    return |(status & enable);
  endfunction

  assign grp3_pend = any_unmasked(rx_latched_status_group3,
                                  grp3_mask & grp3_impl);
  assign grp4_pend = any_unmasked(rx_latched_status_group4, grp4_mask);
  assign hdlc_pend = any_unmasked(rx_latched_status_hdlc, hdlc_mask);
  assign grp7_pend = any_unmasked(rx_latched_status_group7, grp7_eff);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_irq_summary <= `RIMB_RESET_VAL;
    end else begin
      rx_irq_summary <= `RIMB_RESET_VAL;
      rx_irq_summary[`RIMB_SUM_GRP3] <= grp3_pend;
      rx_irq_summary[`RIMB_SUM_GRP4] <= grp4_pend;
      rx_irq_summary[`RIMB_SUM_HDLC] <= hdlc_pend;
      rx_irq_summary[`RIMB_SUM_GRP7] <= grp7_pend;
    end
  end

  // Same terms as the summary, so request and summary never disagree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= grp3_pend | grp4_pend | hdlc_pend | grp7_pend;
    end
  end

endmodule // rimb_bank

`default_nettype wire

// ---- bench/rimb_bank_chk.sv ----
// Port-level assertions of the receive mask bank
`default_nettype none
`include "rimb_consts.svh"
module rimb_bank_chk #(
  parameter int CHANNELS   = 32,
  parameter int INTEG_BITS = 48
) (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [7:0]          rx_latched_status_group3,
  input wire logic [7:0]          rx_latched_status_group4,
  input wire logic [7:0]          rx_latched_status_hdlc,
  input wire logic [7:0]          rx_latched_status_group7,
  input wire logic [CHANNELS-1:0] channel_signaling_changed,
  input wire logic [7:0]          rx_irq_summary,
  input wire logic                rx_irq,
  input wire logic                signaling_change_flag,
  input wire logic                loop_up_restart,
  input wire logic                line_mode_e1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic acc;
  logic done;
  logic quiet;
  assign acc   = psel && penable && !pready;
  assign done  = psel && penable && pready && pwrite;
  assign quiet = ~|{rx_latched_status_group3, rx_latched_status_group4,
                    rx_latched_status_hdlc, rx_latched_status_group7};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_acc; acc; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  sequence s_lup_wr; done && paddr == {`RIMB_IDX_LUP1, 2'b00}; endsequence
  property p_ready_wait; s_acc |=> s_ans; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_misalign; acc && paddr[1:0] != 2'b00 |=> pslverr; endproperty
  property p_rdata_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  property p_restart; s_lup_wr |=> loop_up_restart ##1 !loop_up_restart;
  endproperty
  property p_restart_src;
    loop_up_restart |-> $past(done && paddr == {`RIMB_IDX_LUP1, 2'b00});
  endproperty
  property p_irq_sum; rx_irq == (|rx_irq_summary); endproperty
  property p_quiet; quiet |=> !rx_irq && rx_irq_summary == 8'h00; endproperty
  property p_flag_src;
    signaling_change_flag |-> $past(|channel_signaling_changed);
  endproperty
  property p_mode_hold;
    !$past(done && paddr == {`RIMB_IDX_CFG, 2'b00}) |=> $stable(line_mode_e1);
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready timing");
  a_err_ready: assert property (p_err_ready) else $error("lone error");
  a_misalign: assert property (p_misalign) else $error("misaligned ok");
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper data");
  a_restart: assert property (p_restart) else $error("no restart");
  a_restart_src: assert property (p_restart_src) else $error("restart");
  a_irq_sum: assert property (p_irq_sum) else $error("irq vs summary");
  a_quiet: assert property (p_quiet) else $error("irq when quiet");
  a_flag_src: assert property (p_flag_src) else $error("flag cause");
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
endmodule // rimb_bank_chk

bind rimb_bank rimb_bank_chk #(.CHANNELS(CHANNELS), .INTEG_BITS(INTEG_BITS))
  u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .rx_latched_status_group3, .rx_latched_status_group4,
  .rx_latched_status_hdlc, .rx_latched_status_group7,
  .channel_signaling_changed, .rx_irq_summary, .rx_irq,
  .signaling_change_flag, .loop_up_restart, .line_mode_e1);
`default_nettype wire

// ---- bench/rimb_line_src.sv ----
// Received line model repeating a code pattern
`default_nettype none
module rimb_line_src (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire logic [7:0] pattern,
  input  wire logic [3:0] len,
  output logic            bit_out,
  output logic            valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] pos;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pos     <= 4'h0;
      valid   <= 1'b0;
      bit_out <= 1'b0;
    end else if (enable) begin
      bit_out <= pattern[4'h7 - pos];
      valid   <= 1'b1;
      pos     <= (pos + 4'h1 == len) ? 4'h0 : pos + 4'h1;
    end else begin
      // Idle line toggles so a stale bit never looks held
      valid   <= 1'b0;
      bit_out <= ~bit_out;
      pos     <= 4'h0;
    end
  end
endmodule // rimb_line_src
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench of the receive mask bank
`default_nettype none
`include "rimb_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, src_en = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, chg = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  st3 = 8'h00, st4 = 8'h00, st5 = 8'h00, st7 = 8'h00, sum;
  logic        pready, pslverr, lb, lbv, irq, flag, lrst, ldet, mode;
  int          num_errors = 0, checks = 0;
  logic [9:0]  idx [9] = '{`RIMB_IDX_GRP3, `RIMB_IDX_GRP4, `RIMB_IDX_HDLC,
    `RIMB_IDX_GRP7, `RIMB_IDX_CSE1, `RIMB_IDX_CSE2, `RIMB_IDX_CSE3,
    `RIMB_IDX_CSE4, `RIMB_IDX_LUP1};
  logic [7:0]  t1m [9] = '{8'hFF, 8'hEF, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF};
  always #12.5 clk = ~clk;
  // Small integration count keeps the detector run short
  rimb_bank #(.CHANNELS(32), .INTEG_BITS(4)) uut (.clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .rx_latched_status_group3(st3), .rx_latched_status_group4(st4),
    .rx_latched_status_hdlc(st5), .rx_latched_status_group7(st7),
    .channel_signaling_changed(chg), .rx_line_bit(lb),
    .rx_line_bit_valid(lbv), .rx_irq_summary(sum), .rx_irq(irq),
    .signaling_change_flag(flag), .loop_up_restart(lrst),
    .loop_up_detect(ldet), .line_mode_e1(mode));
  rimb_line_src src (.clk, .rst_b, .enable(src_en), .pattern(8'hA0),
    .len(4'h3), .bit_out(lb), .valid(lbv));
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("[ERR] %0t no ready", $time);
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, {24'h0, d});
  endtask
  task automatic rchk(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task automatic st(input logic [7:0] a, b, c, e, s);
    st3 <= a;
    st4 <= b;
    st5 <= c;
    st7 <= e;
    repeat (2) @(posedge clk);
    chk({24'h0, sum}, {24'h0, s});
    chk({31'h0, irq}, {31'h0, |s});
  endtask
  task automatic pulse(input int ch, input logic e);
    chg[ch] <= 1'b1;
    @(posedge clk);
    chg <= 32'h0;
    @(posedge clk);
    chk({31'h0, flag}, {31'h0, e});
  endtask
  task automatic wait_det(input logic e);
    int n;
    n = 0;
    while (ldet !== e && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, ldet}, {31'h0, e});
    if (ldet !== e) stop_test();
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rchk(idx[i], 8'h00);
    rchk(`RIMB_IDX_CFG, 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(idx[i], 8'hFF);
      rchk(idx[i], t1m[i]);
    end
    apb(1'b0, 12'h284, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h289, 32'h0);
    chk({31'h0, er}, 32'h1);
    rchk(`RIMB_IDX_GRP3, 8'hFF);
    wr(`RIMB_IDX_CFG, 8'h01);
    rchk(`RIMB_IDX_GRP3, 8'hBB);
    chk({31'h0, mode}, 32'h1);
    rchk(`RIMB_IDX_GRP7, 8'h00);
    wr(`RIMB_IDX_GRP7, 8'hFF);
    rchk(`RIMB_IDX_GRP7, 8'h03);
    wr(`RIMB_IDX_GRP4, 8'h08);
    st(8'h44, 8'hF7, 8'hC0, 8'hFC, 8'h00);
    st(8'h80, 8'h08, 8'h20, 8'h02, 8'h5C);
    st(8'h00, 8'h00, 8'h00, 8'h01, 8'h40);
    st(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    pulse(31, 1'b1);
    wr(`RIMB_IDX_CSE1, 8'hFE);
    pulse(0, 1'b0);
    pulse(1, 1'b1);
    wr(`RIMB_IDX_CFG, 8'h04);
    pulse(31, 1'b0);
    chk({31'h0, mode}, 32'h0);
    rchk(`RIMB_IDX_GRP7, 8'h3F);
    st(8'h40, 8'h00, 8'h00, 8'h20, 8'h44);
    st(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    wr(`RIMB_IDX_LUP1, 8'hA7);
    chk({31'h0, lrst}, 32'h1);
    src_en <= 1'b1;
    wait_det(1'b1);
    rchk(`RIMB_IDX_STAT, 8'h01);
    // Lane 0 off keeps the pattern, so only the restart can drop detect
    pstrb <= 4'h0;
    wr(`RIMB_IDX_LUP1, 8'h00);
    pstrb <= 4'hF;
    chk({31'h0, ldet}, 32'h0);
    rchk(`RIMB_IDX_LUP1, 8'hA7);
    wait_det(1'b1);
    wr(`RIMB_IDX_LUP1, 8'h40);
    wait_det(1'b0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
